//--- rtl/did_top.sv
// APB slave and input path of the digital input debounce block.
// Assumes comparator output arrives asynchronously; threshold DAC and ADC are analog, outside this logic.
`timescale 1ns/1ps
`include "did_regs.svh"
module did_top
    import did_pkg::*;
#(
    parameter int SAMPLE_CYCLES = `DID_SAMPLE_CYCLES,
    parameter int EDGE_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comp_buffered,
    input wire logic comp_unbuffered,
    input wire logic [15:0] conversion_result_one,
    output logic unbuffered_input_enable,
    output logic [6:0] comp_threshold_code,
    output logic threshold_supply_ratio,
    output logic [13:0] loop_dac_code,
    output logic [2:0] adc_range_sel,
    output logic general_pin_a_out,
    output logic general_pin_a_oe_n
);
    localparam int SC_W = $clog2(SAMPLE_CYCLES + 1);

    logic [31:0] input_config_one_reg;
    logic [31:0] input_config_two_reg;
    logic [31:0] general_pin_setup_reg;
    logic [31:0] adc_setup_reg;
    logic [EDGE_W-1:0] edge_count_reg;
    logic [1:0] buf_sync_reg;
    logic [1:0] unbuf_sync_reg;
    logic [SC_W-1:0] tick_count_reg;
    logic sample_tick;
    logic sample_reg;
    logic deb_state;
    logic deb_prev_reg;
    logic status_reg;
    logic general_pin_a_next;
    logic [31:0] prdata_next;
    logic wr_en;
    logic rd_en;
    logic mapped;
    did_count_type target;
    did_out_sel_type out_sel;

    // Sample count for each debounce code; durations in ns over the 800 ns sample period
    function automatic did_count_type code_to_count(input logic [4:0] code);
        int unsigned ns;
        ns = 0;
        case (code)
            5'h01: ns = 13000;
            5'h02: ns = 18700;
            5'h03: ns = 24400;
            5'h04: ns = 32500;
            5'h05: ns = 42300;
            5'h06: ns = 56100;
            5'h07: ns = 75600;
            5'h08: ns = 100800;
            5'h09: ns = 130100;
            5'h0a: ns = 180500;
            5'h0b: ns = 240600;
            5'h0c: ns = 320300;
            5'h0d: ns = 420300;
            5'h0e: ns = 560200;
            5'h0f: ns = 750400;
            5'h10: ns = 1000800;
            5'h11: ns = 1300800;
            5'h12: ns = 1800800;
            5'h13: ns = 2400800;
            5'h14: ns = 3200800;
            5'h15: ns = 4200800;
            5'h16: ns = 5600800;
            5'h17: ns = 7500700;
            5'h18: ns = 10000700;
            5'h19: ns = 13000700;
            5'h1a: ns = 18000600;
            5'h1b: ns = 24000600;
            5'h1c: ns = 32000500;
            5'h1d: ns = 42000400;
            5'h1e: ns = 56000300;
            5'h1f: ns = 75000000;
            default: ns = 0;
        endcase
        return did_count_type'(ns / `DID_SAMPLE_NS);
    endfunction

    // One decoder gates writes and the error response; the read mux keeps its own case of the map
    function automatic logic is_mapped(input logic [11:0] a);
        return (a == `DID_OFS_CONFIG_ONE) || (a == `DID_OFS_CONFIG_TWO) || (a == `DID_OFS_PIN_SETUP) ||
               (a == `DID_OFS_STATUS) || (a == `DID_OFS_EDGE_COUNT) || (a == `DID_OFS_ADC_SETUP) ||
               (a == `DID_OFS_RESULT_ONE);
    endfunction

    // Byte-lane merge of a write into a register under its writable mask
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] st, input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r & mask;
    endfunction

    // Zero wait states; unmapped addresses answer with an error
    assign mapped = is_mapped(paddr);
    assign wr_en = psel && penable && pwrite && mapped;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Configuration writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_config_one_reg <= 32'h0000_0000;
            input_config_two_reg <= 32'h0000_0000;
            general_pin_setup_reg <= 32'h0000_0000;
            adc_setup_reg <= 32'h0000_0000;
        end else if (wr_en) begin
            case (paddr)
                `DID_OFS_CONFIG_ONE: input_config_one_reg <= merge(input_config_one_reg, pwdata, pstrb, `DID_C1_MASK);
                `DID_OFS_CONFIG_TWO: input_config_two_reg <= merge(input_config_two_reg, pwdata, pstrb, `DID_C2_MASK);
                `DID_OFS_PIN_SETUP: general_pin_setup_reg <= merge(general_pin_setup_reg, pwdata, pstrb,
                                                                   `DID_PIN_MASK);
                `DID_OFS_ADC_SETUP: adc_setup_reg <= merge(adc_setup_reg, pwdata, pstrb, `DID_ADC_SETUP_MASK);
                default: ;
            endcase
        end
    end

    // Read data captured in the setup cycle so prdata comes from a flip-flop
    always_comb begin
        prdata_next = 32'h0000_0000;
        case (paddr)
            `DID_OFS_CONFIG_ONE: prdata_next = input_config_one_reg;
            `DID_OFS_CONFIG_TWO: prdata_next = input_config_two_reg;
            `DID_OFS_PIN_SETUP: prdata_next = general_pin_setup_reg;
            `DID_OFS_STATUS: prdata_next = {31'h0000_0000, status_reg};
            `DID_OFS_EDGE_COUNT: prdata_next = 32'(edge_count_reg);
            `DID_OFS_ADC_SETUP: prdata_next = adc_setup_reg;
            `DID_OFS_RESULT_ONE: prdata_next = {16'h0000, conversion_result_one};
            default: prdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= prdata_next;
        end
    end

    // Analog-side controls; the ADC path is independent of the digital input logic
    assign unbuffered_input_enable = input_config_two_reg[`DID_C2_UNBUF_EN];
    assign comp_threshold_code = input_config_two_reg[`DID_C2_THRESH_MSB:`DID_C2_THRESH_LSB];
    assign threshold_supply_ratio = input_config_two_reg[`DID_C2_THRESH_MODE];
    assign loop_dac_code = adc_setup_reg[`DID_DAC_MSB:0];
    assign adc_range_sel = adc_setup_reg[`DID_ADC_RANGE_MSB:`DID_ADC_RANGE_LSB];

    // Both comparator outputs are synchronised; the mux looks only at second stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_sync_reg <= 2'h0;
            unbuf_sync_reg <= 2'h0;
        end else begin
            buf_sync_reg <= {buf_sync_reg[0], comp_buffered};
            unbuf_sync_reg <= {unbuf_sync_reg[0], comp_unbuffered};
        end
    end

    // Sample strobe every 800 ns; a coarse clock keeps the debounce counter narrow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_count_reg <= '0;
        end else if (tick_count_reg == SC_W'(SAMPLE_CYCLES - 1)) begin
            tick_count_reg <= '0;
        end else begin
            tick_count_reg <= tick_count_reg + 1'b1;
        end
    end
    assign sample_tick = (tick_count_reg == SC_W'(SAMPLE_CYCLES - 1));

    // Sampled comparator value from the selected source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_reg <= 1'b0;
        end else if (sample_tick) begin
            sample_reg <= unbuffered_input_enable ? unbuf_sync_reg[1] : buf_sync_reg[1];
        end
    end

    assign target = code_to_count(input_config_one_reg[`DID_C1_TIME_MSB:`DID_C1_TIME_LSB]);

    did_debouncer u_deb (
        .pclk(pclk),
        .presetn(presetn),
        .sample_tick(sample_tick),
        .sample_val(sample_reg),
        .mode(input_config_one_reg[`DID_C1_MODE]),
        .bypass(input_config_one_reg[`DID_C1_TIME_MSB:`DID_C1_TIME_LSB] == 5'h00),
        .target(target),
        .state_out(deb_state)
    );

    assign out_sel = did_out_sel_type'(input_config_one_reg[`DID_C1_OUT_SEL_MSB:`DID_C1_OUT_SEL_LSB]);

    // Status shows debounced, direct or inverted form; invert bit applies to the debounced form
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 1'b0;
        end else begin
            case (out_sel)
                DID_OUT_DIRECT: status_reg <= sample_reg;
                DID_OUT_INVERTED: status_reg <= ~sample_reg;
                default: status_reg <= deb_state ^ input_config_one_reg[`DID_C1_INVERT];
            endcase
        end
    end

    // Edge counter follows the status bit, so the invert choice picks rising or falling edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deb_prev_reg <= 1'b0;
            edge_count_reg <= '0;
        end else begin
            deb_prev_reg <= status_reg;
            if (input_config_one_reg[`DID_C1_COUNT_EN] && status_reg && !deb_prev_reg) begin
                edge_count_reg <= edge_count_reg + 1'b1;
            end
        end
    end

    // General pin A drives the status form only when set up for the input function
    assign general_pin_a_next = status_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            general_pin_a_out <= 1'b0;
            general_pin_a_oe_n <= 1'b1;
        end else begin
            general_pin_a_out <= general_pin_a_next;
            general_pin_a_oe_n <= (general_pin_setup_reg[`DID_PIN_SEL_MSB:0] != `DID_PIN_FUNC_INPUT);
        end
    end
endmodule

//--- rtl/did_regs.svh
// Constants, register offsets and field layouts of the digital input debounce block.
// Assumes inclusion by its bare name from the package and the modules; definitions only.
// What this block does
// - Comparator watches buffered low sense pin, or channel output pin when unbuffered enabled.
// - Comparator output is sampled regularly; samples feed the debouncer, not raw level.
// - Sample clock period about 800 ns; one count per sample period.
// - Five-bit time field; code zero bypasses debouncer, passing sampled state straight.
// - Codes 01 to 1F select 31 fixed durations from 0.0130 ms to 75 ms.
// - One mode bit picks debounce algorithm; mode 0 after reset.
// - Mode 0: high samples count one way, low the other; output flips at target.
// - Mode 0 counts once sample differs from output; direction reverses on return.
// - Mode 1: counter increments while sample differs; at target output toggles, counter clears.
// - Mode 1: counter clears whenever sample returns to the debounced value.
// - Status and general pin A show debounced, direct or inverted comparator result.
// - When general pin A is set up for input, it drives the status form (debounced, direct or inverted).
// - Threshold reference selectable: fixed voltage or proportional to analog supply.
// - Loop-powered mode: ADC defaults to terminal voltage on 0 V to 12 V range.
// - Digital input works without the ADC; ADC stays available meanwhile.
// - Invert bit inverts debounced state before the status register, else unchanged.
// - Edge counter counts rising edges of the status form while enabled, freezes, resets to zero, rolls over.
`ifndef DID_REGS_SVH
`define DID_REGS_SVH

// Register byte offsets
`define DID_OFS_CONFIG_ONE 12'h000
`define DID_OFS_CONFIG_TWO 12'h004
`define DID_OFS_PIN_SETUP 12'h008
`define DID_OFS_STATUS 12'h00c
`define DID_OFS_EDGE_COUNT 12'h010
`define DID_OFS_ADC_SETUP 12'h014
`define DID_OFS_RESULT_ONE 12'h018

// input_config_one fields
`define DID_C1_TIME_LSB 0
`define DID_C1_TIME_MSB 4
`define DID_C1_MODE 5
`define DID_C1_INVERT 6
`define DID_C1_COUNT_EN 7
`define DID_C1_OUT_SEL_LSB 8
`define DID_C1_OUT_SEL_MSB 9
`define DID_C1_MASK 32'h0000_03ff

// input_config_two fields
`define DID_C2_THRESH_LSB 0
`define DID_C2_THRESH_MSB 6
`define DID_C2_THRESH_MODE 7
`define DID_C2_UNBUF_EN 8
`define DID_C2_MASK 32'h0000_01ff

// general_pin_setup: low three bits select the pin function
`define DID_PIN_SEL_MSB 2
`define DID_PIN_FUNC_INPUT 3'h3
`define DID_PIN_MASK 32'h0000_0007

// Loop-powered DAC code and ADC range defaults
`define DID_DAC_MSB 13
`define DID_ADC_RANGE_LSB 16
`define DID_ADC_RANGE_MSB 18
`define DID_ADC_RANGE_12V 3'h0
`define DID_ADC_SETUP_MASK 32'h0007_3fff

// Sample clock timing
`define DID_CLK_HZ 50000000
`define DID_SAMPLE_NS 800
`define DID_SAMPLE_CYCLES ((`DID_SAMPLE_NS * (`DID_CLK_HZ / 1000000)) / 1000)

`define DID_CNT_W 17

`endif

//--- rtl/did_pkg.sv
// Types shared by the digital input debounce design.
// Assumes did_regs.svh on the include path.
`include "did_regs.svh"
package did_pkg;
    typedef enum logic [1:0] {
        DID_OUT_DEBOUNCED = 2'h0,
        DID_OUT_DIRECT = 2'h1,
        DID_OUT_INVERTED = 2'h2
    } did_out_sel_type;

    typedef logic [`DID_CNT_W-1:0] did_count_type;
endpackage

//--- rtl/did_debouncer.sv
// Two-mode debouncer working on sampled comparator values.
// Assumes sample_tick is a one-cycle strobe from the same clock domain.
`timescale 1ns/1ps
`include "did_regs.svh"
module did_debouncer
    import did_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sample_tick,
    input wire logic sample_val,
    input wire logic mode,
    input wire logic bypass,
    input wire did_count_type target,
    output logic state_out
);
    did_count_type count_reg;

    // Mode 0 walks up toward the new level and back down on a return; mode 1 restarts on any return
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
            state_out <= 1'b0;
        end else if (sample_tick) begin
            if (bypass) begin
                state_out <= sample_val;
                count_reg <= '0;
            end else if (mode == 1'b0) begin
                if (sample_val != state_out) begin
                    if (count_reg + 1'b1 >= target) begin
                        state_out <= sample_val;
                        count_reg <= '0;
                    end else begin
                        count_reg <= count_reg + 1'b1;
                    end
                end else begin
                    // Direction reverses by counting back toward zero
                    if (count_reg != '0) begin
                        count_reg <= count_reg - 1'b1;
                    end
                end
            end else begin
                if (sample_val != state_out) begin
                    if (count_reg + 1'b1 >= target) begin
                        state_out <= ~state_out;
                        count_reg <= '0;
                    end else begin
                        count_reg <= count_reg + 1'b1;
                    end
                end else begin
                    count_reg <= '0;
                end
            end
        end
    end
endmodule

//--- verification/did_checker.sv
// Assertion checker for the digital input debounce top; watches its ports only.
// Assumes a single pclk domain and zero-wait bus accesses with all byte lanes enabled.
`timescale 1ns/1ps
module did_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic [15:0] conversion_result_one,
    input wire logic unbuffered_input_enable,
    input wire logic [6:0] comp_threshold_code,
    input wire logic threshold_supply_ratio,
    input wire logic [13:0] loop_dac_code,
    input wire logic [2:0] adc_range_sel,
    input wire logic general_pin_a_oe_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Full-word writes only; the bench also keeps all byte lanes enabled, so partial lanes go unchecked
    wire logic wr_acc = psel && penable && pwrite && pstrb == 4'hf;
    wire logic rd_acc = psel && penable && !pwrite;

    unbuf_follow_a: assert property (wr_acc && paddr == 12'h004 |=>
        unbuffered_input_enable == $past(pwdata[8])) else $error("unbuffered select did not follow write");
    unbuf_readback_a: assert property (rd_acc && paddr == 12'h004 |->
        prdata[8] == unbuffered_input_enable) else $error("unbuffered select readback differs");
    thresh_mode_a: assert property (wr_acc && paddr == 12'h004 |=> threshold_supply_ratio == $past(pwdata[7])
        && comp_threshold_code == $past(pwdata[6:0])) else $error("threshold setup did not follow write");
    dac_follow_a: assert property (wr_acc && paddr == 12'h014 |=>
        loop_dac_code == $past(pwdata[13:0])) else $error("loop current code did not follow write");
    range_follow_a: assert property (wr_acc && paddr == 12'h014 |=>
        adc_range_sel == $past(pwdata[18:16])) else $error("range select did not follow write");
    pin_enable_a: assert property (wr_acc && paddr == 12'h008 && pwdata[2:0] == 3'h3 |->
        ##[1:2] !general_pin_a_oe_n) else $error("pin A not driven after input function set");
    reset_state_a: assert property ($rose(presetn) |-> general_pin_a_oe_n && adc_range_sel == 3'h0
        && !unbuffered_input_enable) else $error("outputs not at reset state after release");
    result_read_a: assert property (rd_acc && paddr == 12'h018 |->
        prdata[15:0] == $past(conversion_result_one)) else $error("conversion result readback differs");
endmodule

bind did_top did_checker i_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .conversion_result_one(conversion_result_one), .unbuffered_input_enable(unbuffered_input_enable),
    .comp_threshold_code(comp_threshold_code), .threshold_supply_ratio(threshold_supply_ratio),
    .loop_dac_code(loop_dac_code), .adc_range_sel(adc_range_sel), .general_pin_a_oe_n(general_pin_a_oe_n));

//--- verification/did_sensor.sv
// Field sensor on the terminal: drives both comparator paths and the ADC code.
// Assumes the bench picks the level, which path carries it and the terminal voltage.
`timescale 1ns/1ps
module did_sensor (
    input wire logic level,
    input wire logic fast_path,
    input wire logic [15:0] terminal_mv,
    output logic comp_buffered,
    output logic comp_unbuffered,
    output logic [15:0] adc_code
);
    // The unwatched path carries the inverse, so a wrong path choice shows at once
    assign comp_buffered = fast_path ? ~level : level;
    assign comp_unbuffered = fast_path ? level : ~level;
    // Terminal voltage scaled to a 16-bit code over the 12 V span
    assign adc_code = 16'((32'(terminal_mv) * 32'd65536) / 32'd12000);
endmodule

//--- verification/digital_input_debounce_test.sv
// Self-checking bench for the digital input debounce block.
// Assumes did_top with a short sample period, the field sensor model and the bound checker.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module digital_input_debounce_test;
    localparam int SC = 4;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, level = 0, fast_path = 0;
    logic [15:0] terminal_mv = 16'd6000, adc_code;
    logic comp_b, comp_u, unbuf_en, ratio, pin_out, pin_oe_n;
    logic [6:0] thr;
    logic [13:0] dac;
    logic [2:0] rng;
    logic [32:0] expq[$];
    int fails = 0, compares = 0;

    did_top #(.SAMPLE_CYCLES(SC)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comp_buffered(comp_b), .comp_unbuffered(comp_u), .conversion_result_one(adc_code),
        .unbuffered_input_enable(unbuf_en), .comp_threshold_code(thr), .threshold_supply_ratio(ratio),
        .loop_dac_code(dac), .adc_range_sel(rng), .general_pin_a_out(pin_out), .general_pin_a_oe_n(pin_oe_n));
    did_sensor i_sensor (.level(level), .fast_path(fast_path), .terminal_mv(terminal_mv),
        .comp_buffered(comp_b), .comp_unbuffered(comp_u), .adc_code(adc_code));

    initial begin
        forever #10 pclk = ~pclk;
    end

    // One bus transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(0, a, 32'h0);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic results;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Each completed read retires the oldest expectation: error flag and data together
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && expq.size() > 0) begin
            `CHK({pslverr, prdata}, expq.pop_front())
        end
    end

    initial begin
        #(20 * 20000);
        fails++;
        results();
    end

    initial begin
        void'($urandom(24));
        repeat (4) @(posedge pclk);
        presetn <= 1;
        rd(12'h000, 33'h0);
        rd(12'h00c, 33'h0);
        rd(12'h014, 33'h0);
        rd(12'h008, 33'h0);
        rd(12'h01c, {1'b1, 32'h0});
        rd(12'h018, {1'b0, 32'h8000});
        d = $urandom & 32'h3fff;
        apb(1, 12'h014, d);
        rd(12'h014, {1'b0, d});
        d = $urandom & 32'hff;
        apb(1, 12'h004, d);
        rd(12'h004, {1'b0, d});
        // Bypass with the fast path carrying the level, then back to the buffered path
        level <= 1;
        fast_path <= 1;
        apb(1, 12'h004, 32'h100);
        idle(6 * SC);
        rd(12'h00c, 33'h1);
        apb(1, 12'h004, 32'h0);
        idle(6 * SC);
        rd(12'h00c, 33'h0);
        apb(1, 12'h000, 32'h40);
        rd(12'h00c, 33'h1);
        // Output forms: a short pulse is too brief for code 01, so only the raw forms move
        fast_path <= 0;
        for (int s = 0; s < 3; s++) begin
            level <= 0;
            apb(1, 12'h000, 32'h0);
            idle(6 * SC);
            apb(1, 12'h000, 32'h1 | (s << 8));
            level <= 1;
            idle(3 * SC);
            rd(12'h00c, {32'h0, s == 1});
        end
        // A short dip: mode 0 counts back and still reaches target, mode 1 starts over
        for (int m = 0; m < 2; m++) begin
            level <= 0;
            apb(1, 12'h000, 32'h0);
            idle(6 * SC);
            apb(1, 12'h000, 32'h1 | (m << 5));
            level <= 1;
            idle(12 * SC);
            level <= 0;
            idle(2 * SC);
            level <= 1;
            idle(10 * SC);
            rd(12'h00c, {32'h0, m == 0});
            idle(16 * SC);
            rd(12'h00c, 33'h1);
        end
        // Pin A driven with the state while rising edges are counted
        apb(1, 12'h008, 32'h3);
        apb(1, 12'h000, 32'h80);
        for (int i = 0; i < 3; i++) begin
            // Sync, two sample ticks, status and pin stages need up to twelve cycles
            level <= 0;
            idle(4 * SC);
            `CHK(pin_oe_n, 1'b0)
            `CHK(pin_out, 1'b0)
            level <= 1;
            idle(4 * SC);
            `CHK(pin_out, 1'b1)
        end
        rd(12'h010, 33'h3);
        apb(1, 12'h000, 32'h0);
        level <= 0;
        idle(3 * SC);
        level <= 1;
        idle(3 * SC);
        rd(12'h010, 33'h3);
        idle(4);
        results();
    end
endmodule
